// ### verilog/ruc_defs.svh
// register offsets, field positions, reset values and timing counts for the serial channel
`ifndef RUC_DEFS_SVH
`define RUC_DEFS_SVH
`define RUC_OFS_DATA 5'h00
`define RUC_OFS_IER 5'h01
`define RUC_OFS_IIR 5'h02
`define RUC_OFS_LCR 5'h03
`define RUC_OFS_MCR 5'h04
`define RUC_OFS_LSR 5'h05
`define RUC_OFS_BOARD 5'h10
`define RUC_LCR_STOP2 2
`define RUC_LCR_PAREN 3
`define RUC_LCR_EVEN 4
`define RUC_LCR_STICK 5
`define RUC_LCR_BREAK 6
`define RUC_LCR_DIVSEL 7
`define RUC_MCR_RTS 1
`define RUC_MCR_IRQGATE 3
`define RUC_IER_RX 0
`define RUC_IER_THRE 1
`define RUC_IIR_NONE 8'h01
`define RUC_IIR_THRE 8'h02
`define RUC_IIR_RX 8'h04
`define RUC_LCR_RST 8'h00
`define RUC_MCR_RST 8'h00
`define RUC_IER_RST 8'h00
`define RUC_DIV_RST 16'h000C
`define RUC_REF_HZ 1843200
`define RUC_REF_FAST_HZ (4 * `RUC_REF_HZ)
`define RUC_SYS_HZ 200000000
`define RUC_NCO_GCD 12800
`define RUC_NCO_INC 14'(`RUC_REF_HZ / `RUC_NCO_GCD)
`define RUC_NCO_INC_FAST 14'(`RUC_REF_FAST_HZ / `RUC_NCO_GCD)
`define RUC_NCO_MOD 15'(`RUC_SYS_HZ / `RUC_NCO_GCD)
`define RUC_SUB_LAST 5'h0F
`define RUC_SUB_MID 5'h07
`define RUC_SUB_LAST2 5'h1F
`define RUC_FIRST_LAST_BIT 3'h4
`endif

// ### verilog/ruc_pkg.sv
// state types of the serial channel
package ruc_pkg;
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_START = 5'h02,
      TX_DATA = 5'h04,
      TX_PARITY = 5'h08,
      TX_STOP = 5'h10
   } ruc_tx_state_type;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_PARITY = 5'h08,
      RX_STOP = 5'h10
   } ruc_rx_state_type;
endpackage

// ### verilog/ruc_buffer.sv
// two-entry transmit buffer with valid and ready on both sides
`timescale 1ns/100ps
module ruc_buffer #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [1:0] count_reg, count_next;
   logic wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [WIDTH-1:0] entry_reg [2];
   logic [WIDTH-1:0] entry_next [2];
   logic push, pop;

   assign inReady = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData = entry_reg[rdPtr_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      count_next = count_reg;
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      if (push) begin
         wrPtr_next = ~wrPtr_reg;
      end
      if (pop) begin
         rdPtr_next = ~rdPtr_reg;
      end
      if (push && !pop) begin
         count_next = 2'(count_reg + 2'h1);
      end else if (pop && !push) begin
         count_next = 2'(count_reg - 2'h1);
      end
   end

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : gEntry
         assign entry_next[i] = (push && wrPtr_reg == 1'(i)) ? inData : entry_reg[i];
         always_ff @(posedge sys_clk) begin
            entry_reg[i] <= entry_next[i];
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count_reg <= 2'h0;
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
      end
   end

   // a stalled head word must not move or vanish
   AST_BUF_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
      outValid && !outReady |=> outValid && $stable(outData))
      else $error("buffer head changed while stalled");
endmodule

// ### verilog/ruc_channel.sv
// one asynchronous serial channel with byte-wide host registers and automatic line driver
`timescale 1ns/100ps
`include "ruc_defs.svh"
module ruc_channel
   import ruc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // host i/o bus
   input wire logic [4:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioWrData,
   output logic [7:0] ioRdData,
   // board straps and neighbour
   input wire logic clkOptionFast,
   input wire logic autoMode,
   input wire logic otherChanIrq,
   // serial line and interrupt
   input wire logic rxLine,
   output logic txLine,
   output logic driverEnable,
   output logic rtsOut,
   output logic irqOut
);
   logic [7:0] lineCtl_reg, lineCtl_next, modemCtl_reg, modemCtl_next;
   logic [7:0] intEn_reg, intEn_next, rxBuf_reg, rxBuf_next, rdData_reg, rdData_next;
   logic [15:0] divisor_reg, divisor_next, divCnt_reg, divCnt_next;
   logic [13:0] ncoAcc_reg, ncoAcc_next;
   logic dataReady_reg, dataReady_next, overrun_reg, overrun_next;
   logic parErr_reg, parErr_next, frameErr_reg, frameErr_next;
   logic irq_reg, irq_next, txLine_reg, txLine_next, de_reg, de_next, rts_reg, rts_next;
   ruc_tx_state_type txState_reg, txState_next;
   ruc_rx_state_type rxState_reg, rxState_next;
   logic [4:0] txSub_reg, txSub_next, rxSub_reg, rxSub_next;
   logic [2:0] txBit_reg, txBit_next, rxBit_reg, rxBit_next;
   logic [7:0] txShift_reg, txShift_next, rxShift_reg, rxShift_next;
   logic txPar_reg, txPar_next, rxPar_reg, rxPar_next;
   logic divSel, refTick, divEnd, sampleTick, rxStore, rxFrameBad, rxParBad;
   logic rbrRead, lsrRead, bufInValid, bufInReady, bufOutValid, bufOutReady;
   logic rxPending, thrPending, pending, lineBit;
   logic [14:0] ncoSum;
   logic [2:0] lastBit;
   logic [7:0] bufOutData, rxAligned;

   function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
      return addr == ofs;
   endfunction

   // parity bit for the character as configured; shared by send and receive
   function automatic logic parityBit(input logic [7:0] d, input logic [7:0] lcr);
      logic p;
      p = ^(d & 8'(8'hFF >> (2'h3 - lcr[1:0])));
      if (lcr[`RUC_LCR_STICK]) begin
         return ~lcr[`RUC_LCR_EVEN];
      end
      return lcr[`RUC_LCR_EVEN] ? p : ~p;
   endfunction

   assign divSel = lineCtl_reg[`RUC_LCR_DIVSEL];
   assign lastBit = 3'(`RUC_FIRST_LAST_BIT + {1'b0, lineCtl_reg[1:0]});
   assign rbrRead = ioRead && hit(ioAddr, `RUC_OFS_DATA) && !divSel;
   assign lsrRead = ioRead && hit(ioAddr, `RUC_OFS_LSR);
   // a write while both entries are full is dropped; software polls the empty flag first
   assign bufInValid = ioWrite && hit(ioAddr, `RUC_OFS_DATA) && !divSel;
   assign bufOutReady = (txState_reg == TX_IDLE) && !divSel;
   assign rxPending = intEn_reg[`RUC_IER_RX] && dataReady_reg;
   assign thrPending = intEn_reg[`RUC_IER_THRE] && !bufOutValid;
   assign pending = rxPending || thrPending;

   ruc_buffer #(.WIDTH(8)) txBuffer (
      .sys_clk(sys_clk),
      .reset(reset),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(ioWrData),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOutData)
   );

   // rate generator: fractional accumulator makes the reference, then the divisor
   always_comb begin
      ncoSum = {1'b0, ncoAcc_reg}
             + {1'b0, clkOptionFast ? `RUC_NCO_INC_FAST : `RUC_NCO_INC};
      refTick = ncoSum >= `RUC_NCO_MOD;
      ncoAcc_next = refTick ? 14'(ncoSum - `RUC_NCO_MOD) : ncoSum[13:0];
      // divisor 0 behaves as 1 rather than stalling the line
      divEnd = (divisor_reg <= 16'h0001) || (divCnt_reg >= 16'(divisor_reg - 16'h0001));
      sampleTick = refTick && divEnd;
      divCnt_next = divCnt_reg;
      if (refTick) begin
         divCnt_next = divEnd ? 16'h0000 : 16'(divCnt_reg + 16'h0001);
      end
   end

   // host register writes
   always_comb begin
      lineCtl_next = lineCtl_reg;
      modemCtl_next = modemCtl_reg;
      intEn_next = intEn_reg;
      divisor_next = divisor_reg;
      if (ioWrite) begin
         if (hit(ioAddr, `RUC_OFS_DATA) && divSel) begin
            divisor_next[7:0] = ioWrData;
         end else if (hit(ioAddr, `RUC_OFS_IER) && divSel) begin
            divisor_next[15:8] = ioWrData;
         end else if (hit(ioAddr, `RUC_OFS_IER)) begin
            intEn_next = {6'h00, ioWrData[1:0]};
         end else if (hit(ioAddr, `RUC_OFS_LCR)) begin
            lineCtl_next = ioWrData;
         end else if (hit(ioAddr, `RUC_OFS_MCR)) begin
            modemCtl_next = {3'h0, ioWrData[4:0]};
         end
      end
   end

   // transmitter
   always_comb begin
      txState_next = txState_reg;
      txSub_next = txSub_reg;
      txBit_next = txBit_reg;
      txShift_next = txShift_reg;
      txPar_next = txPar_reg;
      lineBit = 1'b1;
      case (txState_reg)
         TX_IDLE: begin
            if (bufOutValid && !divSel) begin
               txState_next = TX_START;
               txShift_next = bufOutData;
               txPar_next = parityBit(bufOutData, lineCtl_reg);
               txSub_next = 5'h00;
            end
         end
         TX_START: begin
            lineBit = 1'b0;
            if (sampleTick) begin
               txSub_next = 5'(txSub_reg + 5'h01);
               if (txSub_reg == `RUC_SUB_LAST) begin
                  txState_next = TX_DATA;
                  txSub_next = 5'h00;
                  txBit_next = 3'h0;
               end
            end
         end
         TX_DATA: begin
            lineBit = txShift_reg[0];
            if (sampleTick) begin
               txSub_next = 5'(txSub_reg + 5'h01);
               if (txSub_reg == `RUC_SUB_LAST) begin
                  txSub_next = 5'h00;
                  txShift_next = {1'b0, txShift_reg[7:1]};
                  txBit_next = 3'(txBit_reg + 3'h1);
                  if (txBit_reg == lastBit) begin
                     txState_next = lineCtl_reg[`RUC_LCR_PAREN] ? TX_PARITY : TX_STOP;
                  end
               end
            end
         end
         TX_PARITY: begin
            lineBit = txPar_reg;
            if (sampleTick) begin
               txSub_next = 5'(txSub_reg + 5'h01);
               if (txSub_reg == `RUC_SUB_LAST) begin
                  txState_next = TX_STOP;
                  txSub_next = 5'h00;
               end
            end
         end
         TX_STOP: begin
            if (sampleTick) begin
               txSub_next = 5'(txSub_reg + 5'h01);
               if (txSub_reg == (lineCtl_reg[`RUC_LCR_STOP2] ?
                     `RUC_SUB_LAST2 : `RUC_SUB_LAST)) begin
                  txState_next = TX_IDLE;
               end
            end
         end
         default: begin
            txState_next = TX_IDLE;
         end
      endcase
      txLine_next = lineBit && !lineCtl_reg[`RUC_LCR_BREAK];
      rts_next = modemCtl_reg[`RUC_MCR_RTS];
      // automatic mode keeps the driver on through back-to-back characters
      de_next = autoMode ? (bufOutValid || txState_reg != TX_IDLE)
                         : modemCtl_reg[`RUC_MCR_RTS];
   end

   // receiver: start bit checked at mid-bit, every later bit sampled sixteen ticks on
   always_comb begin
      rxState_next = rxState_reg;
      rxSub_next = rxSub_reg;
      rxBit_next = rxBit_reg;
      rxShift_next = rxShift_reg;
      rxPar_next = rxPar_reg;
      rxStore = 1'b0;
      rxAligned = 8'(rxShift_reg >> (3'h7 - lastBit));
      rxFrameBad = !rxLine;
      rxParBad = lineCtl_reg[`RUC_LCR_PAREN] && (rxPar_reg != parityBit(rxAligned, lineCtl_reg));
      if (sampleTick) begin
         rxSub_next = 5'(rxSub_reg + 5'h01);
         case (rxState_reg)
            RX_IDLE: begin
               rxSub_next = 5'h00;
               if (!rxLine) begin
                  rxState_next = RX_START;
               end
            end
            RX_START: begin
               if (rxSub_reg == `RUC_SUB_MID) begin
                  rxSub_next = 5'h00;
                  rxBit_next = 3'h0;
                  rxState_next = rxLine ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rxSub_reg == `RUC_SUB_LAST) begin
                  rxSub_next = 5'h00;
                  rxShift_next = {rxLine, rxShift_reg[7:1]};
                  rxBit_next = 3'(rxBit_reg + 3'h1);
                  if (rxBit_reg == lastBit) begin
                     rxState_next = lineCtl_reg[`RUC_LCR_PAREN] ? RX_PARITY : RX_STOP;
                  end
               end
            end
            RX_PARITY: begin
               if (rxSub_reg == `RUC_SUB_LAST) begin
                  rxSub_next = 5'h00;
                  rxPar_next = rxLine;
                  rxState_next = RX_STOP;
               end
            end
            RX_STOP: begin
               if (rxSub_reg == `RUC_SUB_LAST) begin
                  rxStore = 1'b1;
                  rxState_next = RX_IDLE;
               end
            end
            default: begin
               rxState_next = RX_IDLE;
            end
         endcase
      end
   end

   // status flags: a new event wins over a clearing read in the same cycle
   always_comb begin
      rxBuf_next = rxStore ? rxAligned : rxBuf_reg;
      dataReady_next = rxStore || (dataReady_reg && !rbrRead);
      overrun_next = (rxStore && dataReady_reg && !rbrRead) || (overrun_reg && !lsrRead);
      parErr_next = (rxStore && rxParBad) || (parErr_reg && !lsrRead);
      frameErr_next = (rxStore && rxFrameBad) || (frameErr_reg && !lsrRead);
      irq_next = pending && modemCtl_reg[`RUC_MCR_IRQGATE];
      rdData_next = rdData_reg;
      if (ioRead) begin
         if (hit(ioAddr, `RUC_OFS_DATA)) begin
            rdData_next = divSel ? divisor_reg[7:0] : rxBuf_reg;
         end else if (hit(ioAddr, `RUC_OFS_IER)) begin
            rdData_next = divSel ? divisor_reg[15:8] : intEn_reg;
         end else if (hit(ioAddr, `RUC_OFS_IIR)) begin
            rdData_next = rxPending ? `RUC_IIR_RX
                        : (thrPending ? `RUC_IIR_THRE : `RUC_IIR_NONE);
         end else if (hit(ioAddr, `RUC_OFS_LCR)) begin
            rdData_next = lineCtl_reg;
         end else if (hit(ioAddr, `RUC_OFS_MCR)) begin
            rdData_next = modemCtl_reg;
         end else if (hit(ioAddr, `RUC_OFS_LSR)) begin
            rdData_next = {1'b0, !bufOutValid && txState_reg == TX_IDLE, !bufOutValid,
                           1'b0, frameErr_reg, parErr_reg, overrun_reg, dataReady_reg};
         end else if (hit(ioAddr, `RUC_OFS_BOARD)) begin
            rdData_next = {6'h00, otherChanIrq, irq_reg};
         end else begin
            rdData_next = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lineCtl_reg <= `RUC_LCR_RST;
         modemCtl_reg <= `RUC_MCR_RST;
         intEn_reg <= `RUC_IER_RST;
         divisor_reg <= `RUC_DIV_RST;
         divCnt_reg <= 16'h0000;
         ncoAcc_reg <= 14'h0000;
         rxBuf_reg <= 8'h00;
         rdData_reg <= 8'h00;
         dataReady_reg <= 1'b0;
         overrun_reg <= 1'b0;
         parErr_reg <= 1'b0;
         frameErr_reg <= 1'b0;
         irq_reg <= 1'b0;
         txLine_reg <= 1'b1;
         de_reg <= 1'b0;
         rts_reg <= 1'b0;
         txState_reg <= TX_IDLE;
         txSub_reg <= 5'h00;
         txBit_reg <= 3'h0;
         txShift_reg <= 8'h00;
         txPar_reg <= 1'b0;
         rxState_reg <= RX_IDLE;
         rxSub_reg <= 5'h00;
         rxBit_reg <= 3'h0;
         rxShift_reg <= 8'h00;
         rxPar_reg <= 1'b0;
      end else begin
         lineCtl_reg <= lineCtl_next;
         modemCtl_reg <= modemCtl_next;
         intEn_reg <= intEn_next;
         divisor_reg <= divisor_next;
         divCnt_reg <= divCnt_next;
         ncoAcc_reg <= ncoAcc_next;
         rxBuf_reg <= rxBuf_next;
         rdData_reg <= rdData_next;
         dataReady_reg <= dataReady_next;
         overrun_reg <= overrun_next;
         parErr_reg <= parErr_next;
         frameErr_reg <= frameErr_next;
         irq_reg <= irq_next;
         txLine_reg <= txLine_next;
         de_reg <= de_next;
         rts_reg <= rts_next;
         txState_reg <= txState_next;
         txSub_reg <= txSub_next;
         txBit_reg <= txBit_next;
         txShift_reg <= txShift_next;
         txPar_reg <= txPar_next;
         rxState_reg <= rxState_next;
         rxSub_reg <= rxSub_next;
         rxBit_reg <= rxBit_next;
         rxShift_reg <= rxShift_next;
         rxPar_reg <= rxPar_next;
      end
   end

   assign ioRdData = rdData_reg;
   assign txLine = txLine_reg;
   assign driverEnable = de_reg;
   assign rtsOut = rts_reg;
   assign irqOut = irq_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_DIV_LOW: assert property (ioWrite && divSel && hit(ioAddr, `RUC_OFS_DATA)
      |=> divisor_reg[7:0] == $past(ioWrData) && divisor_reg[15:8] == $past(divisor_reg[15:8]))
      else $error("divisor low byte not taken");
   AST_DIVSEL_HOLD: assert property (divSel && txState_reg == TX_IDLE
      |=> txState_reg == TX_IDLE)
      else $error("character sent while divisor selected");
   AST_STORE_READY: assert property (rxStore |=> dataReady_reg ##1 1'b1)
      else $error("received character not flagged");
   AST_READ_CLEARS: assert property (rbrRead && !rxStore |=> !dataReady_reg)
      else $error("buffer read left data ready set");
   AST_IIR_RX: assert property (ioRead && hit(ioAddr, `RUC_OFS_IIR) && rxPending
      |=> ioRdData == `RUC_IIR_RX)
      else $error("receive interrupt code wrong");
   AST_IRQ_GATE: assert property (!modemCtl_reg[`RUC_MCR_IRQGATE] |=> !irqOut)
      else $error("interrupt escaped the gate");
   AST_AUTO_ON: assert property (autoMode && txState_reg != TX_IDLE |=> driverEnable)
      else $error("driver off while sending");
   AST_AUTO_OFF: assert property (autoMode && txState_reg == TX_STOP
      && txState_next == TX_IDLE && !bufOutValid && !bufInValid |=> ##1 !driverEnable)
      else $error("driver not released after stop bit");
   AST_MANUAL_RTS: assert property (!autoMode && $stable(modemCtl_reg)
      |=> driverEnable == $past(modemCtl_reg[`RUC_MCR_RTS]) && rtsOut == driverEnable)
      else $error("driver does not follow request-to-send");
   AST_BOARD: assert property (ioRead && hit(ioAddr, `RUC_OFS_BOARD)
      |=> ioRdData[1] == $past(otherChanIrq) && ioRdData[0] == $past(irqOut))
      else $error("board status bits wrong");
endmodule

// ### bench/ruc_remote_node.sv
// remote node on the differential line: sends and captures characters
`timescale 1ns/100ps
module ruc_remote_node #(
   parameter int BIT_CYC = 1736
) (
   input wire logic sys_clk,
   output logic rxLine,
   input wire logic txLine
);
   initial rxLine = 1'b1;
   // 8 data bits lsb first, one stop bit, changed at the falling edge only
   task automatic send_byte(input logic [7:0] b);
      rxLine = 1'b0;
      repeat (BIT_CYC) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         rxLine = b[i];
         repeat (BIT_CYC) @(negedge sys_clk);
      end
      rxLine = 1'b1;
      repeat (BIT_CYC) @(negedge sys_clk);
   endtask
   // samples mid-bit so a slightly off reference still lands inside each bit
   task automatic get_byte(output logic [7:0] b, output logic ok);
      int n;
      for (n = 0; n < 30000 && txLine !== 1'b0; n++) @(negedge sys_clk);
      ok = (txLine === 1'b0);
      repeat (BIT_CYC + BIT_CYC / 2) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = txLine;
         repeat (BIT_CYC) @(negedge sys_clk);
      end
      ok = ok && (txLine === 1'b1);
   endtask
endmodule

// ### bench/rs485_uart_channel_tb.sv
// self-checking bench for the serial channel
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module rs485_uart_channel_tb;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] ioAddr = 5'h00;
   logic ioWrite = 1'b0;
   logic ioRead = 1'b0;
   logic [7:0] ioWrData = 8'h00;
   logic [7:0] ioRdData;
   logic clkOptionFast = 1'b0;
   logic autoMode = 1'b0;
   logic otherChanIrq = 1'b0;
   logic rxLine, txLine, driverEnable, rtsOut, irqOut;
   int errors = 0;
   int tests_run = 0;
   always #2.5 sys_clk = ~sys_clk;
   ruc_channel u_ruc_channel (.sys_clk(sys_clk), .reset(reset), .ioAddr(ioAddr),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
      .clkOptionFast(clkOptionFast), .autoMode(autoMode), .otherChanIrq(otherChanIrq),
      .rxLine(rxLine), .txLine(txLine), .driverEnable(driverEnable), .rtsOut(rtsOut),
      .irqOut(irqOut));
   ruc_remote_node u_ruc_remote_node (.sys_clk(sys_clk), .rxLine(rxLine), .txLine(txLine));
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      ioAddr = a;
      ioWrData = d;
      ioWrite = 1'b1;
      @(negedge sys_clk);
      ioWrite = 1'b0;
   endtask
   // read data is registered at the read edge, so it is settled by the next falling edge
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      ioAddr = a;
      ioRead = 1'b1;
      @(negedge sys_clk);
      ioRead = 1'b0;
      d = ioRdData;
   endtask
   task automatic wait_de(input logic v);
      for (int n = 0; n < 4000 && driverEnable !== v; n++) @(negedge sys_clk);
   endtask
   task automatic test_reset;
      logic [7:0] d;
      `CHK(txLine, 1'b1)
      rd(5'h03, d); `CHK(d, 8'h00)
      rd(5'h02, d); `CHK(d, 8'h01)
      rd(5'h05, d); `CHK(d, 8'h60)
      rd(5'h07, d); `CHK(d, 8'h00)
      rd(5'h10, d); `CHK(d, 8'h00)
      $display("test reset done");
   endtask
   task automatic test_init;
      logic [7:0] d;
      wr(5'h03, 8'h80);
      wr(5'h00, 8'h01);
      wr(5'h01, 8'h00);
      rd(5'h03, d); `CHK(d, 8'h80)
      wr(5'h03, 8'h03);
      rd(5'h03, d); `CHK(d, 8'h03)
      wr(5'h04, 8'h02);
      @(negedge sys_clk);
      `CHK(rtsOut, 1'b1)
      `CHK(driverEnable, 1'b1)
      wr(5'h04, 8'h00);
      @(negedge sys_clk);
      `CHK(rtsOut, 1'b0)
      $display("test init done");
   endtask
   task automatic test_rx;
      logic [7:0] d;
      int n;
      u_ruc_remote_node.send_byte(8'h5A);
      d = 8'h00;
      for (n = 0; n < 4000 && d[0] !== 1'b1; n++) rd(5'h05, d);
      `CHK(d[0], 1'b1)
      rd(5'h02, d); `CHK(d, 8'h01)
      wr(5'h01, 8'h01);
      rd(5'h02, d); `CHK(d, 8'h04)
      `CHK(irqOut, 1'b0)
      otherChanIrq = 1'b1;
      wr(5'h04, 8'h08);
      // the gated interrupt needs one more cycle to reach the output flop
      @(negedge sys_clk);
      rd(5'h10, d); `CHK(d, 8'h03)
      `CHK(irqOut, 1'b1)
      rd(5'h00, d); `CHK(d, 8'h5A)
      rd(5'h00, d);
      rd(5'h05, d); `CHK(d[0], 1'b0)
      rd(5'h02, d); `CHK(d, 8'h01)
      rd(5'h10, d); `CHK(d, 8'h02)
      otherChanIrq = 1'b0;
      $display("test rx done");
   endtask
   task automatic test_tx;
      logic [7:0] b;
      logic ok;
      autoMode = 1'b1;
      wr(5'h01, 8'h00);
      @(negedge sys_clk);
      `CHK(driverEnable, 1'b0)
      fork
         u_ruc_remote_node.get_byte(b, ok);
         begin
            wr(5'h00, 8'hA5);
            wait_de(1'b1);
            `CHK(driverEnable, 1'b1)
         end
      join
      `CHK(ok, 1'b1)
      `CHK(b, 8'hA5)
      `CHK(driverEnable, 1'b1)
      wait_de(1'b0);
      `CHK(driverEnable, 1'b0)
      `CHK(txLine, 1'b1)
      $display("test tx done");
   endtask
   // fast reference with divisor 4 keeps the bit period of divisor 1; two stop bits
   task automatic test_fast;
      logic [7:0] b;
      logic [7:0] d;
      logic ok;
      clkOptionFast = 1'b1;
      wr(5'h03, 8'h80);
      wr(5'h00, 8'h04);
      wr(5'h01, 8'h00);
      rd(5'h00, d); `CHK(d, 8'h04)
      wr(5'h03, 8'h07);
      fork
         u_ruc_remote_node.get_byte(b, ok);
         wr(5'h00, 8'h3C);
      join
      `CHK(ok, 1'b1)
      `CHK(b, 8'h3C)
      repeat (1736) @(negedge sys_clk);
      `CHK(driverEnable, 1'b1)
      `CHK(txLine, 1'b1)
      wait_de(1'b0);
      `CHK(driverEnable, 1'b0)
      clkOptionFast = 1'b0;
      $display("test fast done");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      test_reset;
      test_init;
      test_rx;
      test_tx;
      test_fast;
      close_out;
   end
   // a hang ends the run through the same report
   initial begin
      #450000;
      errors++;
      close_out;
   end
endmodule
